// ### rtl/serial_vid_command_decoder.sv
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "vid_map.svh"

module serial_vid_command_decoder
  import vid_pkg::*;
#(
  parameter logic [1:0] CORE_PHASES_RST = `VID_CORE_PHASES_RST,
  parameter logic [1:0] NB_PHASES_RST   = `VID_NB_PHASES_RST
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        vid_bus_clock,
  input  wire logic        vid_bus_data_in,
  output logic             vid_bus_data_out,
  output logic             vid_bus_data_oe_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [7:0]       coreVoltageCode,
  output logic [12:0]      coreTargetQmv,
  output logic             coreOutputOff,
  output logic             corePowerState0_n,
  output logic             corePowerState1_n,
  output logic             coreDecay,
  output logic             coreLoadLineOff,
  output logic [7:0]       coreLoadLinePct,
  output logic             coreOffsetOff,
  output logic [5:0]       coreOffsetMv,
  output logic [2:0]       coreChanEn,
  output logic             coreDiodeEmulation,
  output logic [7:0]       nbVoltageCode,
  output logic [12:0]      nbTargetQmv,
  output logic             nbOutputOff,
  output logic             nbPowerState0_n,
  output logic             nbPowerState1_n,
  output logic             nbDecay,
  output logic             nbLoadLineOff,
  output logic [7:0]       nbLoadLinePct,
  output logic             nbOffsetOff,
  output logic [5:0]       nbOffsetMv,
  output logic [1:0]       nbChanEn,
  output logic             nbDiodeEmulation,
  output telem_mode_t      telemetryMode
);
  if (CORE_PHASES_RST < 2'h1 || NB_PHASES_RST < 2'h1 ||
      NB_PHASES_RST > 2'h2) begin
    $error("phase count out of range");
  end
  function automatic logic [12:0] target_of(input logic [7:0] code);
    target_of = 13'(`VID_TOP_QMV - `VID_STEP_QMV * {5'h00, code});
  endfunction
  function automatic logic [7:0] ll_pct(input logic [2:0] t);
    ll_pct = 8'(({5'h00, t} - `VID_LL_NEUTRAL) * `VID_LL_STEP_PCT);
  endfunction
  function automatic logic [5:0] ofs_mv(input logic [1:0] t);
    unique case (t)
      `VID_OFS_MINUS: ofs_mv = 6'(-`VID_OFS_STEP_MV);
      `VID_OFS_PLUS:  ofs_mv = `VID_OFS_STEP_MV;
      default:        ofs_mv = 6'h00;
    endcase
  endfunction
  function automatic logic [2:0] chan_mask(input logic [1:0] phases,
                                           input logic       ps0_n);
    // ps0 alone decides shedding; ps1 never changes it
    if (!ps0_n)
      chan_mask = 3'h1;
    else
      chan_mask = 3'(({1'b0, 3'h1} << phases) - 4'h1);
  endfunction
  function automatic logic [31:0] status_of(input reg_set_t r,
                                            input logic [2:0] en);
    status_of = {11'h000, en == 3'h1 && !r.ps0_n, en, r.decay,
                 r.code >= `VID_OFF_CODE, r.ofsTrim, r.llTrim,
                 r.ps1_n, r.ps0_n, r.code};
  endfunction
  // data line is only ever listened to
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      vid_bus_data_out  <= 1'b0;
      vid_bus_data_oe_n <= 1'b1;
    end else begin
      vid_bus_data_out  <= 1'b0;
      vid_bus_data_oe_n <= 1'b1;
    end
  end
  // two-flop synchronisers, third stage feeds the edge detect
  logic [1:0] clkSync;
  logic [1:0] datSync;
  logic       clkPrev;
  logic       datPrev;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync <= 2'h3;
      datSync <= 2'h3;
      clkPrev <= 1'b1;
      datPrev <= 1'b1;
    end else begin
      clkSync <= {clkSync[0], vid_bus_clock};
      datSync <= {datSync[0], vid_bus_data_in};
      clkPrev <= clkSync[1];
      datPrev <= datSync[1];
    end
  end
  logic clkRise;
  logic startSeen;
  logic stopSeen;
  assign clkRise   = clkSync[1] && !clkPrev;
  assign startSeen = clkSync[1] && clkPrev && datPrev && !datSync[1];
  assign stopSeen  = clkSync[1] && clkPrev && !datPrev && datSync[1];
  // bit capture
  link_state_t linkState;
  logic [26:0] frame;
  logic [4:0]  bitCount;
  logic        overrun;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      linkState <= LINK_IDLE;
      frame     <= 27'h0000000;
      bitCount  <= 5'h00;
      overrun   <= 1'b0;
    end else if (startSeen) begin
      linkState <= LINK_RECV; // a repeated start restarts the frame
      bitCount  <= 5'h00;
      overrun   <= 1'b0;
    end else if (stopSeen) begin
      linkState <= LINK_IDLE;
    end else if (linkState == LINK_RECV && clkRise) begin
      if (bitCount < `VID_FRAME_BITS) begin
        frame    <= {frame[25:0], datSync[1]};
        bitCount <= bitCount + 5'h01;
      end else if (bitCount == `VID_FRAME_BITS)
        bitCount <= bitCount + 5'h01; // the stop needs one more clock rise
      else
        overrun <= 1'b1;
    end
  end
  // frame check at stop
  logic frameOk;
  logic frameEnd;
  assign frameEnd = stopSeen && linkState == LINK_RECV;
  assign frameOk  = frameEnd && !overrun &&
                    bitCount == `VID_FRAME_BITS + 5'h01 &&
                    frame[`VID_HDR_MSB:`VID_HDR_LSB] == `VID_HDR_PATTERN &&
                    !frame[`VID_ZERO_BIT];
  reg_set_t cmd;
  always_comb begin
    cmd.code    = {frame[`VID_CODE_HI_MSB:`VID_CODE_HI_LSB],
                   frame[`VID_CODE_LO]};
    cmd.ps0_n   = frame[`VID_PS0_BIT];
    cmd.ps1_n   = frame[`VID_PS1_BIT];
    cmd.llTrim  = frame[`VID_LL_MSB:`VID_LL_LSB];
    cmd.ofsTrim = frame[`VID_OFS_MSB:`VID_OFS_LSB];
    // higher code (lower voltage) with a flag asserted lets the output sag
    cmd.decay   = !(cmd.ps0_n && cmd.ps1_n);
  end
  function automatic reg_set_t apply(input reg_set_t old,
                                     input reg_set_t c);
    apply       = c;
    apply.decay = (c.code > old.code) && c.decay;
  endfunction
  reg_set_t coreSet;
  reg_set_t nbSet;
  localparam reg_set_t SET_RST = '{code: `VID_CODE_RST, ps0_n: 1'b1,
    ps1_n: 1'b1, llTrim: `VID_LL_RST, ofsTrim: `VID_OFS_RST, decay: 1'b0};
  // nothing moves before the stop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      coreSet <= SET_RST;
    else if (frameOk && frame[`VID_CORE_SEL])
      coreSet <= apply(coreSet, cmd);
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      nbSet <= SET_RST;
    else if (frameOk && frame[`VID_NB_SEL])
      nbSet <= apply(nbSet, cmd);
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      telemetryMode <= TELEM_VOLT_CURR;
    else if (frameOk && frame[`VID_TELEM_BIT]) begin
      unique case ({frame[`VID_CORE_SEL], frame[`VID_NB_SEL]})
        2'h1:    telemetryMode <= TELEM_VOLT_CURR;
        2'h0:    telemetryMode <= TELEM_VOLT_ONLY;
        2'h2:    telemetryMode <= TELEM_OFF;
        default: telemetryMode <= telemetryMode;   // reserved
      endcase
    end
  end
  // phase configuration, software owned
  logic [1:0] corePhases;
  logic [1:0] nbPhases;
  logic       apbWrite;
  assign apbWrite = psel && penable && pready && pwrite;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      corePhases <= CORE_PHASES_RST;
      nbPhases   <= NB_PHASES_RST;
    end else if (apbWrite && paddr == `VID_REG_CONFIG) begin
      // unsupported counts are refused, old value kept
      if (pwdata[`VID_CFG_CORE_LSB+:2] != 2'h0)
        corePhases <= pwdata[`VID_CFG_CORE_LSB+:2];
      if (pwdata[`VID_CFG_NB_LSB+:2] inside {2'h1, 2'h2})
        nbPhases <= pwdata[`VID_CFG_NB_LSB+:2];
    end
  end
  // registered regulator outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreVoltageCode    <= `VID_CODE_RST;
      coreTargetQmv      <= 13'h0000;
      coreOutputOff      <= 1'b1;
      corePowerState0_n  <= 1'b1;
      corePowerState1_n  <= 1'b1;
      coreDecay          <= 1'b0;
      coreLoadLineOff    <= 1'b0;
      coreLoadLinePct    <= 8'h00;
      coreOffsetOff      <= 1'b0;
      coreOffsetMv       <= 6'h00;
      coreChanEn         <= 3'h0;
      coreDiodeEmulation <= 1'b0;
    end else begin
      coreVoltageCode    <= coreSet.code;
      coreTargetQmv      <= target_of(coreSet.code);
      coreOutputOff      <= coreSet.code >= `VID_OFF_CODE;
      corePowerState0_n  <= coreSet.ps0_n;
      corePowerState1_n  <= coreSet.ps1_n;
      coreDecay          <= coreSet.decay;
      coreLoadLineOff    <= coreSet.llTrim == `VID_LL_DISABLE;
      coreLoadLinePct    <= ll_pct(coreSet.llTrim);
      coreOffsetOff      <= coreSet.ofsTrim == `VID_OFS_DISABLE;
      coreOffsetMv       <= ofs_mv(coreSet.ofsTrim);
      coreChanEn         <= chan_mask(corePhases, coreSet.ps0_n);
      coreDiodeEmulation <= !coreSet.ps0_n;
    end
  end
  logic [2:0] nbMask;
  assign nbMask = chan_mask(nbPhases, nbSet.ps0_n);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nbVoltageCode    <= `VID_CODE_RST;
      nbTargetQmv      <= 13'h0000;
      nbOutputOff      <= 1'b1;
      nbPowerState0_n  <= 1'b1;
      nbPowerState1_n  <= 1'b1;
      nbDecay          <= 1'b0;
      nbLoadLineOff    <= 1'b0;
      nbLoadLinePct    <= 8'h00;
      nbOffsetOff      <= 1'b0;
      nbOffsetMv       <= 6'h00;
      nbChanEn         <= 2'h0;
      nbDiodeEmulation <= 1'b0;
    end else begin
      nbVoltageCode    <= nbSet.code;
      nbTargetQmv      <= target_of(nbSet.code);
      nbOutputOff      <= nbSet.code >= `VID_OFF_CODE;
      nbPowerState0_n  <= nbSet.ps0_n;
      nbPowerState1_n  <= nbSet.ps1_n;
      nbDecay          <= nbSet.decay;
      nbLoadLineOff    <= nbSet.llTrim == `VID_LL_DISABLE;
      nbLoadLinePct    <= ll_pct(nbSet.llTrim);
      nbOffsetOff      <= nbSet.ofsTrim == `VID_OFS_DISABLE;
      nbOffsetMv       <= ofs_mv(nbSet.ofsTrim);
      nbChanEn         <= nbMask[1:0];
      nbDiodeEmulation <= !nbSet.ps0_n;
    end
  end
  // frame statistics, wrap silently
  logic [7:0] goodCount;
  logic [7:0] badCount;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      goodCount <= 8'h00;
      badCount  <= 8'h00;
    end else if (frameOk)
      goodCount <= goodCount + 8'h01;
    else if (frameEnd)
      badCount <= badCount + 8'h01;
  end
  // apb slave: one wait-free access, data latched in the setup cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel && !penable && !pready;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        unique case (paddr)
          `VID_REG_CONFIG:
            prdata <= {28'h0000000, nbPhases, corePhases};
          `VID_REG_CORE_STATUS:
            prdata <= status_of(coreSet, coreChanEn);
          `VID_REG_NB_STATUS:
            prdata <= status_of(nbSet, {1'b0, nbChanEn});
          `VID_REG_FRAME_STAT:
            prdata <= {8'h00, badCount, goodCount, 6'h00, telemetryMode};
          default:
            pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule

// ### rtl/vid_map.svh
`ifndef VID_MAP_SVH
`define VID_MAP_SVH

// apb byte offsets
`define VID_REG_CONFIG      8'h00
`define VID_REG_CORE_STATUS 8'h04
`define VID_REG_NB_STATUS   8'h08
`define VID_REG_FRAME_STAT  8'h0c

// config register fields and reset values
`define VID_CFG_CORE_LSB    0
`define VID_CFG_NB_LSB      2
`define VID_CORE_PHASES_RST 2'h3
`define VID_NB_PHASES_RST   2'h2

// frame layout, index into the 27-bit shift register (bit n at 27-n)
`define VID_FRAME_BITS      5'h1b
`define VID_HDR_MSB         26
`define VID_HDR_LSB         22
`define VID_HDR_PATTERN     5'h18
`define VID_CORE_SEL        21
`define VID_NB_SEL          20
`define VID_ZERO_BIT        19
`define VID_PS0_BIT         17
`define VID_CODE_HI_MSB     16
`define VID_CODE_HI_LSB     10
`define VID_CODE_LO         8
`define VID_PS1_BIT         7
`define VID_TELEM_BIT       6
`define VID_LL_MSB          5
`define VID_LL_LSB          3
`define VID_OFS_MSB         2
`define VID_OFS_LSB         1

// voltage decode, quarter millivolt units
`define VID_TOP_QMV         13'h1838
`define VID_STEP_QMV        13'h0019
`define VID_OFF_CODE        8'hf8

// trim decode
`define VID_LL_DISABLE      3'h0
`define VID_LL_NEUTRAL      8'h03
`define VID_LL_STEP_PCT     8'h14
`define VID_OFS_DISABLE     2'h0
`define VID_OFS_MINUS       2'h1
`define VID_OFS_PLUS        2'h3
`define VID_OFS_STEP_MV     6'h19

// reset state of each regulator
`define VID_CODE_RST        8'hff
`define VID_LL_RST          3'h3
`define VID_OFS_RST         2'h2

`endif

// ### rtl/vid_pkg.sv
package vid_pkg;

  typedef enum logic [1:0] {
    TELEM_VOLT_CURR,
    TELEM_VOLT_ONLY,
    TELEM_OFF
  } telem_mode_t;

  typedef enum logic {
    LINK_IDLE,
    LINK_RECV
  } link_state_t;

  typedef struct packed {
    logic [7:0] code;
    logic       ps0_n;
    logic       ps1_n;
    logic [2:0] llTrim;
    logic [1:0] ofsTrim;
    logic       decay;
  } reg_set_t;

endpackage

// ### tb/serial_vid_command_decoder_monitor.sv
`timescale 1ns/10ps
module serial_vid_command_decoder_monitor
  import vid_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        vid_bus_clock,
  input wire logic        vid_bus_data_in,
  input wire logic        vid_bus_data_oe_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [7:0]  coreVoltageCode,
  input wire logic [12:0] coreTargetQmv,
  input wire logic        coreOutputOff,
  input wire logic        corePowerState0_n,
  input wire logic [2:0]  coreChanEn,
  input wire logic        coreDiodeEmulation,
  input wire logic [7:0]  nbVoltageCode,
  input wire logic        nbPowerState0_n,
  input wire logic [1:0]  nbChanEn,
  input wire logic        nbDiodeEmulation,
  input wire telem_mode_t telemetryMode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  logic [3:0] stopAge;
  // raw pins, so the age also spans the synchroniser delay
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stopAge <= 4'hf;
    end else if (vid_bus_clock && $rose(vid_bus_data_in)) begin
      stopAge <= 4'h0;
    end else if (stopAge != 4'hf) begin
      stopAge <= stopAge + 4'h1;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_core_shed;
    coreChanEn == 3'h1 && coreDiodeEmulation;
  endsequence
  property p_no_drive;
    vid_bus_data_oe_n;
  endproperty
  property p_apb_answer;
    s_setup |=> pready ##1 !pready;
  endproperty
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  property p_apply_after_stop;
    $changed(coreVoltageCode) || $changed(nbVoltageCode)
      || $changed(telemetryMode) |-> stopAge <= 4'hb;
  endproperty
  property p_off_code;
    coreOutputOff == (coreVoltageCode >= 8'hf8);
  endproperty
  property p_target;
    $past(rst_n, 2) |->
      coreTargetQmv == 13'h1838 - 13'h0019 * {5'h00, coreVoltageCode};
  endproperty
  property p_core_shed;
    !corePowerState0_n |-> s_core_shed;
  endproperty
  property p_nb_shed;
    !nbPowerState0_n |-> nbChanEn == 2'h1 && nbDiodeEmulation;
  endproperty
  a_no_drive: assert property (p_no_drive)
    else $error("data line driven");
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not one cycle");
  a_err_with_ready: assert property (p_err_with_ready)
    else $error("error without ready");
  a_apply_after_stop: assert property (p_apply_after_stop)
    else $error("settings changed without stop");
  a_off_code: assert property (p_off_code)
    else $error("off flag wrong");
  a_target: assert property (p_target)
    else $error("target wrong");
  a_core_shed: assert property (p_core_shed)
    else $error("core not shed");
  a_nb_shed: assert property (p_nb_shed)
    else $error("nb not shed");
endmodule
bind serial_vid_command_decoder serial_vid_command_decoder_monitor mon (.*);

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench
  import vid_pkg::*;
;
  typedef struct packed {
    logic [1:0]  sel;
    logic        p0;
    logic [7:0]  c;
    logic        p1;
    logic        t;
    logic [2:0]  ll;
    logic [1:0]  ofs;
    telem_mode_t tel;
  } row_t;
  logic        ref_clk, rst_n, vid_bus_clock, hostData, vid_bus_data_in;
  logic        psel, penable, pwrite, pready, pslverr, er;
  logic        vid_bus_data_out, vid_bus_data_oe_n;
  logic [7:0]  paddr, coreVoltageCode, nbVoltageCode;
  logic [7:0]  coreLoadLinePct, nbLoadLinePct;
  logic [31:0] pwdata, prdata, rd;
  logic [12:0] coreTargetQmv, nbTargetQmv;
  logic        coreOutputOff, corePowerState0_n, corePowerState1_n;
  logic        coreDecay, coreLoadLineOff, coreOffsetOff, coreDiodeEmulation;
  logic        nbOutputOff, nbPowerState0_n, nbPowerState1_n, nbDecay;
  logic        nbLoadLineOff, nbOffsetOff, nbDiodeEmulation;
  logic [5:0]  coreOffsetMv, nbOffsetMv;
  logic [2:0]  coreChanEn;
  logic [1:0]  nbChanEn;
  telem_mode_t telemetryMode, eTel;
  logic [7:0]  eC[2];
  logic        eP0[2], eP1[2], eD[2];
  logic [2:0]  eL[2];
  logic [1:0]  eO[2];
  int          ePh[2];
  int          err_total, check_count, cycles;
  row_t        rows[9] = '{
    '{2'b10, 1'b1, 8'h40, 1'b1, 1'b0, 3'h0, 2'h0, TELEM_VOLT_CURR},
    '{2'b01, 1'b1, 8'h10, 1'b1, 1'b1, 3'h1, 2'h1, TELEM_VOLT_CURR},
    '{2'b11, 1'b0, 8'hf8, 1'b1, 1'b0, 3'h2, 2'h2, TELEM_VOLT_CURR},
    '{2'b10, 1'b0, 8'hf7, 1'b0, 1'b0, 3'h3, 2'h3, TELEM_VOLT_CURR},
    '{2'b10, 1'b1, 8'h00, 1'b0, 1'b0, 3'h4, 2'h0, TELEM_VOLT_CURR},
    '{2'b00, 1'b1, 8'h55, 1'b1, 1'b1, 3'h5, 2'h1, TELEM_VOLT_ONLY},
    '{2'b01, 1'b1, 8'h7f, 1'b0, 1'b0, 3'h6, 2'h3, TELEM_VOLT_ONLY},
    '{2'b11, 1'b1, 8'hff, 1'b1, 1'b1, 3'h7, 2'h2, TELEM_VOLT_ONLY},
    '{2'b10, 1'b1, 8'h20, 1'b1, 1'b1, 3'h0, 2'h0, TELEM_OFF}};
  serial_vid_command_decoder dut (.*);
  vid_master_model host (.vid_bus_clock(vid_bus_clock), .dataDrive(hostData));
  // pull-up: the dut may only ever pull the line low
  assign vid_bus_data_in = hostData & (vid_bus_data_oe_n | vid_bus_data_out);
  always #20 ref_clk = ~ref_clk;
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  function automatic logic [26:0] frame(input row_t r, input logic [4:0] h);
    return {h, r.sel, 1'b0, 1'b1, r.p0, r.c[7:1], 1'b1, r.c[0], r.p1, r.t,
            r.ll, r.ofs, 1'b1};
  endfunction
  function automatic logic [44:0] expv(input int i);
    logic [2:0] ch;
    logic [5:0] mv;
    ch = eP0[i] ? 3'((1 << ePh[i]) - 1) : 3'h1;
    mv = eO[i] == 2'h1 ? 6'h27 : (eO[i] == 2'h3 ? 6'h19 : 6'h00);
    return {eC[i], 13'(6200 - 25 * int'(eC[i])), eC[i] >= 8'hf8, eP0[i],
            eP1[i], eD[i], eL[i] == 3'h0, 8'((int'(eL[i]) - 3) * 20),
            eO[i] == 2'h0, mv, !eP0[i], ch};
  endfunction
  task automatic check_all();
    chk({coreVoltageCode, coreTargetQmv, coreOutputOff, corePowerState0_n,
         corePowerState1_n, coreDecay, coreLoadLineOff, coreLoadLinePct,
         coreOffsetOff, coreOffsetMv, coreDiodeEmulation, coreChanEn},
        expv(0));
    chk({nbVoltageCode, nbTargetQmv, nbOutputOff, nbPowerState0_n,
         nbPowerState1_n, nbDecay, nbLoadLineOff, nbLoadLinePct, nbOffsetOff,
         nbOffsetMv, nbDiodeEmulation, 1'b0, nbChanEn}, expv(1));
    chk(telemetryMode, eTel);
    chk({vid_bus_data_oe_n, vid_bus_data_out}, 2'b10);
  endtask
  task automatic init_exp();
    eC = '{8'hff, 8'hff};
    eP0 = '{1'b1, 1'b1};
    eP1 = '{1'b1, 1'b1};
    eD = '{1'b0, 1'b0};
    eL = '{3'h3, 3'h3};
    eO = '{2'h2, 2'h2};
    ePh = '{3, 2};
    eTel = TELEM_VOLT_CURR;
  endtask
  task automatic apply_row(input row_t r);
    for (int i = 0; i < 2; i++) begin
      if (r.sel[1 - i]) begin
        eD[i] = r.c > eC[i] && !(r.p0 && r.p1);
        eC[i] = r.c;
        eP0[i] = r.p0;
        eP1[i] = r.p1;
        eL[i] = r.ll;
        eO[i] = r.ofs;
      end
    end
    eTel = r.tel;
    host.send(frame(r, 5'h18), 27);
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      wrap_up();
    end
  end
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    err_total = 0;
    check_count = 0;
    cycles = 0;
    init_exp();
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check_all();
    $display("reset state done");
    foreach (rows[i]) begin
      apply_row(rows[i]);
      check_all();
      $display("row %0d done", i);
    end
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk({er, rd}, {1'b0, 32'h0000000b});
    apb(1'b0, 8'h10, 32'h0, rd, er);
    chk({er, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h04, 32'hffffffff, rd, er);
    apb(1'b0, 8'h04, 32'h0, rd, er);
    chk(rd[15:0], {eC[0] >= 8'hf8, eO[0], eL[0], eP1[0], eP0[0], eC[0]});
    apb(1'b1, 8'h00, 32'h6, rd, er);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk(rd, 32'h6);
    apb(1'b1, 8'h00, 32'hc, rd, er);
    apb(1'b0, 8'h00, 32'h0, rd, er);
    chk(rd, 32'h6);
    ePh = '{2, 1};
    apply_row('{2'b01, 1'b1, 8'h30, 1'b1, 1'b1, 3'h3, 2'h2, TELEM_VOLT_CURR});
    check_all();
    host.send(frame(rows[0], 5'h19), 27);
    host.send(frame(rows[2], 5'h18), 20);
    repeat (10) @(posedge ref_clk);
    check_all();
    apb(1'b0, 8'h0c, 32'h0, rd, er);
    chk(rd[23:8], 16'h020a);
    $display("awkward cases done");
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    init_exp();
    repeat (2) @(posedge ref_clk);
    check_all();
    $display("second reset done");
    wrap_up();
  end
endmodule

// ### tb/vid_master_model.sv
`timescale 1ns/10ps
module vid_master_model (
  output logic vid_bus_clock,
  output logic dataDrive
);
  initial begin
    vid_bus_clock = 1'b1;
    dataDrive     = 1'b1;
  end
  // clock stands high between frames; released data reads as pull-up high
  task automatic send(input logic [26:0] f, input int n);
    #10; // pin moves stay clear of the sampling edge
    dataDrive = 1'b0;
    #160;
    for (int i = 26; i > 26 - n; i--) begin
      vid_bus_clock = 1'b0;
      #80;
      dataDrive = f[i];
      #80;
      vid_bus_clock = 1'b1;
      #160;
    end
    vid_bus_clock = 1'b0;
    #80;
    dataDrive = 1'b0;
    #80;
    vid_bus_clock = 1'b1;
    #80;
    dataDrive = 1'b1;
    #400;
  endtask
endmodule
